// File: mpf_link_partner.sv
// Far-side model: pause frame source and transmitter stand-in
module mpf_link_partner (
   input wire logic clk_sys, // System clock
   input wire logic rst_n, // Async reset, active low
   output logic rx_byte_valid, // Byte strobe
   output logic [7:0] rx_byte, // Received byte
   output logic rx_frame_end, // End of frame pulse
   output logic rx_frame_good, // CRC good
   output logic tx_busy, // Sending a frame
   input wire logic tx_pause_req, // Pause frame wanted
   input wire logic [15:0] tx_pause_value, // Time field
   output logic tx_pause_done // Pause frame sent
);
   timeunit 1ns;
   timeprecision 100ps;
   int done_delay = 4;
   int wait_cnt;
   logic [15:0] last_value;

   initial begin
      rx_byte_valid = 1'b0;
      rx_byte = 8'h00;
      rx_frame_end = 1'b0;
      rx_frame_good = 1'b0;
   end

   // ----------
   // Frame source
   // ----------
   task automatic send_frame(input logic [47:0] da, input logic [7:0] tlo,
      input logic [15:0] ptime);
      logic [7:0] b;
      for (int i = 0; i < 64; i++) begin
         case (i)
            0, 1, 2, 3, 4, 5: b = da[47 - 8 * i -: 8];
            12: b = 8'h88;
            13: b = tlo;
            14: b = 8'h00;
            15: b = 8'h01;
            16: b = ptime[15:8];
            17: b = ptime[7:0];
            default: b = 8'(i) ^ 8'h5a; // Source, pad and check bytes
         endcase
         @(posedge clk_sys);
         rx_byte_valid <= 1'b1;
         rx_byte <= b;
      end
      @(posedge clk_sys);
      rx_byte_valid <= 1'b0;
      rx_byte <= ~b; // Released line shows no stale byte
      rx_frame_end <= 1'b1;
      rx_frame_good <= 1'b1;
      @(posedge clk_sys);
      rx_frame_end <= 1'b0;
      rx_frame_good <= 1'b0;
   endtask

   // ----------
   // Transmitter: finishes a pause frame after done_delay + 1 cycles of request
   // ----------
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wait_cnt <= 0;
         tx_pause_done <= 1'b0;
         tx_busy <= 1'b0;
      end else if (tx_pause_done) begin
         tx_pause_done <= 1'b0;
         tx_busy <= 1'b0;
         wait_cnt <= 0;
      end else if (tx_pause_req) begin
         tx_busy <= 1'b1;
         wait_cnt <= wait_cnt + 1;
         if (wait_cnt >= done_delay) begin
            tx_pause_done <= 1'b1;
            last_value <= tx_pause_value;
         end
      end
   end
endmodule // mpf_link_partner

// File: mpf_pause_ctrl.sv
// Pause frame flow control: pause reception, tx hold, pause generation
// How it works
// - Pause frame is a 64-byte minimum frame; code accepts 60 bytes or more
// - Recognise type bytes 88 then 80
// - Accept own address or reserved multicast address
// - React within 512 bit times of end
// - Resume on expiry or zero-time pause
// - Load 16-bit counter; decrement per slot; hold zero
// - Nonzero counter blocks new data frames only
// - Act on pause whatever receive FIFO fill
// - Store pause frame if room; drop multicast optionally
// - Above threshold: congested, send configured pause
// - Queue pause until current transmit ends; tx_busy is not used, request is raised at once
// - Stay congested until receive FIFO empty
// - Re-pause mode: repeat pause before own expiry
// - Resume mode: zero-time pause once FIFO empty
// - After own pause expiry, watch FIFO again
// - Both modes combine: resume or re-pause
// - Send full time; own timer low bits cleared
// - Time below 32: no own timer, repeat
// - Time below 32, resume only: no resume
// - Status paused/sending; count sent and received pauses
// - Pause time 16 bits, default 4000h
// - Config byte: honor, re-pause, resume, drop bits
//
// The register offsets and strobed register access were left to the implementer.
module mpf_pause_ctrl #(
   parameter int SLOT_CYC_10 = mpf_pkg::MPF_SLOT_CYC_10
) (
   input wire logic clk_sys, // System clock
   input wire logic rst_n, // Async reset
   input wire logic [7:0] reg_addr, // Register byte address
   input wire logic [31:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [31:0] reg_rdata, // Read data, cycle after strobe
   input wire logic [47:0] station_addr, // Own individual address
   input wire logic link_speed_100, // 1: 100 Mb/s, 0: 10 Mb/s
   input wire logic rx_byte_valid, // Received byte strobe
   input wire logic [7:0] rx_byte, // Received byte
   input wire logic rx_frame_end, // End of received frame
   input wire logic rx_frame_good, // Frame CRC good, with end
   input wire logic rx_fifo_room, // Receive FIFO has room
   input wire logic [mpf_pkg::MPF_FILL_W-1:0] rx_fifo_level, // Fill bytes
   output logic rx_fc_discard, // Pause frame not to be stored
   input wire logic tx_busy, // Transmitter sending a frame
   output logic tx_data_allow, // New data frame may start
   output logic tx_pause_req, // Pause frame wanted
   output logic [15:0] tx_pause_value, // Time field to send
   input wire logic tx_pause_done // Pause frame sent
);
   import mpf_pkg::*;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] cfg_ff;
   logic [15:0] ptime_ff;
   logic [MPF_FILL_W-1:0] thresh_ff;
   logic [15:0] txcnt_ff;
   logic [15:0] rxcnt_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic [12:0] slot_ff;
   logic [5:0] bcnt_ff;
   logic indiv_ok_ff;
   logic mcast_ok_ff;
   logic type_ok_ff;
   logic op_ok_ff;
   logic [15:0] rx_time_ff;
   logic [15:0] pause_cnt_ff;
   logic [15:0] own_cnt_ff;
   logic cong_ff;
   logic xon_sent_ff;
   logic allow_ff;
   logic discard_ff;
   logic req_ff;
   logic [15:0] value_ff;
   mpf_state_t state_ff;
   mpf_state_t nxt_state;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire honor_en = cfg_ff[MPF_CFG_HONOR_BIT];
   wire send_en = cfg_ff[MPF_CFG_SEND_EN_BIT];
   wire repause = cfg_ff[MPF_CFG_REPAUSE_BIT];
   wire resume = cfg_ff[MPF_CFG_RESUME_BIT];
   wire drop_mc = cfg_ff[MPF_CFG_DROP_BIT];
   wire wr_cfg = reg_wr && (reg_addr == MPF_REG_CFG);
   wire wr_ptime = reg_wr && (reg_addr == MPF_REG_PTIME);
   wire wr_thresh = reg_wr && (reg_addr == MPF_REG_THRESH);
   wire [31:0] status_word = {30'h0, req_ff, pause_cnt_ff != 16'h0};
   wire fifo_empty = (rx_fifo_level == '0);
   wire over_thresh = (rx_fifo_level > thresh_ff);
   wire ptime_big = (ptime_ff >= MPF_PTIME_MIN);
   wire [12:0] slot_last = link_speed_100 ?
      13'(MPF_SLOT_CYC_100 - 1) : 13'(SLOT_CYC_10 - 1);
   wire slot_tick = (slot_ff >= slot_last);

   always_comb begin
      case (reg_addr)
         MPF_REG_CFG: nxt_rdata = {24'h0, cfg_ff};
         MPF_REG_PTIME: nxt_rdata = {16'h0, ptime_ff};
         MPF_REG_THRESH: nxt_rdata = {20'h0, thresh_ff};
         MPF_REG_STATUS: nxt_rdata = status_word;
         MPF_REG_TXCNT: nxt_rdata = {16'h0, txcnt_ff};
         MPF_REG_RXCNT: nxt_rdata = {16'h0, rxcnt_ff};
         default: nxt_rdata = 32'h0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff <= MPF_CFG_RST;
         ptime_ff <= MPF_PTIME_RST;
         thresh_ff <= MPF_THRESH_RST;
         rdata_ff <= 32'h0;
      end else begin
         if (wr_cfg) cfg_ff <= reg_wdata[7:0];
         if (wr_ptime) ptime_ff <= reg_wdata[15:0];
         if (wr_thresh) thresh_ff <= reg_wdata[MPF_FILL_W-1:0];
         rdata_ff <= reg_rd ? nxt_rdata : 32'h0;
      end
   end

   // ------------------------------------------------------------
   // Slot time prescaler
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) slot_ff <= 13'h0;
      else slot_ff <= slot_tick ? 13'h0 : slot_ff + 13'h1;
   end

   // ------------------------------------------------------------
   // Received pause frame parser
   // ------------------------------------------------------------
   wire [47:0] own_sh = station_addr << {bcnt_ff[2:0], 3'b000};
   wire [47:0] mc_sh = MPF_MCAST_DA << {bcnt_ff[2:0], 3'b000};
   wire in_da = (bcnt_ff < MPF_POS_DA_END);
   wire own_match = (rx_byte == own_sh[47:40]);
   wire mc_match = (rx_byte == mc_sh[47:40]);
   wire [5:0] nxt_bcnt = (bcnt_ff == 6'h3f) ? bcnt_ff : bcnt_ff + 6'h1;
   wire fc_frame = rx_frame_end && rx_frame_good && type_ok_ff &&
      op_ok_ff && (bcnt_ff >= MPF_FRAME_MIN);
   wire fc_addr = indiv_ok_ff || mcast_ok_ff;
   wire pause_hit = fc_frame && fc_addr && honor_en;
   wire fc_keep = rx_fifo_room && (indiv_ok_ff || !drop_mc);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bcnt_ff <= 6'h0;
         indiv_ok_ff <= 1'b1;
         mcast_ok_ff <= 1'b1;
      end else if (rx_frame_end) begin
         bcnt_ff <= 6'h0;
         indiv_ok_ff <= 1'b1;
         mcast_ok_ff <= 1'b1;
      end else if (rx_byte_valid) begin
         bcnt_ff <= nxt_bcnt;
         if (in_da) indiv_ok_ff <= indiv_ok_ff && own_match;
         if (in_da) mcast_ok_ff <= mcast_ok_ff && mc_match;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         type_ok_ff <= 1'b0;
         op_ok_ff <= 1'b0;
         rx_time_ff <= 16'h0;
      end else if (rx_byte_valid && !rx_frame_end) begin
         case (bcnt_ff)
            MPF_POS_TYPE_HI: type_ok_ff <= (rx_byte == MPF_TYPE_HI);
            MPF_POS_TYPE_LO:
               type_ok_ff <= type_ok_ff && (rx_byte == MPF_TYPE_LO);
            MPF_POS_OP_HI: op_ok_ff <= (rx_byte == MPF_OP_HI);
            MPF_POS_OP_LO: op_ok_ff <= op_ok_ff && (rx_byte == MPF_OP_LO);
            MPF_POS_TIME_HI: rx_time_ff[15:8] <= rx_byte;
            MPF_POS_TIME_LO: rx_time_ff[7:0] <= rx_byte;
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pause counter and transmit hold
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pause_cnt_ff <= 16'h0;
         allow_ff <= 1'b1;
         discard_ff <= 1'b0;
         rxcnt_ff <= 16'h0;
      end else begin
         if (pause_hit) pause_cnt_ff <= rx_time_ff;
         else if (slot_tick && pause_cnt_ff != 16'h0)
            pause_cnt_ff <= pause_cnt_ff - 16'h1;
         allow_ff <= !(honor_en && pause_cnt_ff != 16'h0);
         discard_ff <= fc_frame && fc_addr && !fc_keep;
         if (pause_hit) rxcnt_ff <= rxcnt_ff + 16'h1;
      end
   end

   // ------------------------------------------------------------
   // Congestion and pause generation
   // ------------------------------------------------------------
   wire own_done = (own_cnt_ff == 16'h0);
   wire xon_ok = resume && fifo_empty && !xon_sent_ff &&
      (ptime_big || repause);
   wire repeat_ok = repause && cong_ff && !fifo_empty && own_done &&
      !xon_sent_ff;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         MPF_IDLE:
            if (send_en && over_thresh) nxt_state = MPF_SEND;
         MPF_SEND:
            if (tx_pause_done) nxt_state = MPF_WAIT;
         MPF_WAIT: begin
            if (xon_ok) nxt_state = MPF_XON;
            else if (repeat_ok) nxt_state = MPF_SEND;
            else if (own_done && (fifo_empty || !repause) && !resume)
               nxt_state = MPF_IDLE;
            else if (own_done && (xon_sent_ff || !ptime_big))
               nxt_state = MPF_IDLE;
         end
         MPF_XON:
            if (tx_pause_done) nxt_state = MPF_WAIT;
         default: nxt_state = MPF_IDLE;
      endcase
   end

   wire enter_send = (nxt_state == MPF_SEND) && (state_ff != MPF_SEND);
   wire enter_xon = (nxt_state == MPF_XON) && (state_ff != MPF_XON);
   wire sent_pause = (state_ff == MPF_SEND) && tx_pause_done;
   wire sent_frame = sent_pause || ((state_ff == MPF_XON) && tx_pause_done);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= MPF_IDLE;
         req_ff <= 1'b0;
         value_ff <= 16'h0;
         txcnt_ff <= 16'h0;
      end else begin
         state_ff <= nxt_state;
         // Request held until the transmitter finishes its frame
         if (enter_send || enter_xon) req_ff <= 1'b1;
         else if (tx_pause_done) req_ff <= 1'b0;
         if (enter_send) value_ff <= ptime_ff;
         else if (enter_xon) value_ff <= 16'h0;
         if (sent_frame) txcnt_ff <= txcnt_ff + 16'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         own_cnt_ff <= 16'h0;
         cong_ff <= 1'b0;
         xon_sent_ff <= 1'b0;
      end else begin
         if (sent_pause)
            own_cnt_ff <= ptime_big ? (ptime_ff & MPF_OWN_MASK)
               : 16'h0;
         else if (slot_tick && !own_done)
            own_cnt_ff <= own_cnt_ff - 16'h1;
         if (over_thresh && send_en) cong_ff <= 1'b1;
         else if (fifo_empty) cong_ff <= 1'b0;
         if (state_ff == MPF_XON && tx_pause_done) xon_sent_ff <= 1'b1;
         else if (state_ff == MPF_IDLE || sent_pause) xon_sent_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign reg_rdata = rdata_ff;
   assign rx_fc_discard = discard_ff;
   assign tx_data_allow = allow_ff;
   assign tx_pause_req = req_ff;
   assign tx_pause_value = value_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_hold_when_paused: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (honor_en && pause_cnt_ff != 16'h0) |=> !tx_data_allow)
      else $error("data frames allowed while paused");

   a_reload_on_pause: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      pause_hit |=> pause_cnt_ff == $past(rx_time_ff))
      else $error("pause counter not loaded from frame");

   a_zero_time_resume: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (pause_hit && rx_time_ff == 16'h0) |=> ##1 tx_data_allow)
      else $error("zero-time pause did not release transmit");

   a_count_down_slot: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (slot_tick && !pause_hit && pause_cnt_ff != 16'h0)
      |=> pause_cnt_ff == $past(pause_cnt_ff) - 16'h1)
      else $error("pause counter missed a slot");

   a_keep_indiv_frame: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (fc_frame && indiv_ok_ff && rx_fifo_room) |=> !rx_fc_discard)
      else $error("individual pause frame discarded");

   a_own_timer_mask: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (sent_pause && ptime_big) |=> own_cnt_ff == (ptime_ff & MPF_OWN_MASK))
      else $error("own timer load wrong");

   a_small_no_timer: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (sent_pause && !ptime_big) |=> own_cnt_ff == 16'h0)
      else $error("own timer loaded for short time");

   a_stay_congested: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (cong_ff && !fifo_empty) |=> cong_ff)
      else $error("congestion left with bytes in fifo");

   a_count_received: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      pause_hit |=> rxcnt_ff == $past(rxcnt_ff) + 16'h1)
      else $error("received pause not counted");

   a_req_until_done: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (tx_pause_req && !tx_pause_done) |=> tx_pause_req)
      else $error("pause request withdrawn before sent");

endmodule // mpf_pause_ctrl

// File: mpf_pause_ctrl_test.sv
// Self-checking testbench for the pause flow control block
module mpf_pause_ctrl_test;
   timeunit 1ns;
   timeprecision 100ps;
   import mpf_pkg::*;
   localparam int SLOT = 16;
   localparam logic [47:0] OWN_DA = 48'h02a0b1c2d3e4;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic link_speed_100 = 1'b0;
   logic rx_byte_valid, rx_frame_end, rx_frame_good, rx_fc_discard;
   logic [7:0] rx_byte;
   logic rx_fifo_room = 1'b1;
   logic [MPF_FILL_W-1:0] rx_fifo_level = '0;
   logic tx_busy, tx_data_allow, tx_pause_req, tx_pause_done;
   logic [15:0] tx_pause_value;
   int err_total = 0;
   int total_checks = 0;

   always #5 clk_sys = ~clk_sys;

   mpf_pause_ctrl #(.SLOT_CYC_10(SLOT)) mpf_pause_ctrl_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .station_addr(OWN_DA),
      .link_speed_100(link_speed_100), .rx_byte_valid(rx_byte_valid),
      .rx_byte(rx_byte), .rx_frame_end(rx_frame_end),
      .rx_frame_good(rx_frame_good), .rx_fifo_room(rx_fifo_room),
      .rx_fifo_level(rx_fifo_level), .rx_fc_discard(rx_fc_discard),
      .tx_busy(tx_busy), .tx_data_allow(tx_data_allow),
      .tx_pause_req(tx_pause_req), .tx_pause_value(tx_pause_value),
      .tx_pause_done(tx_pause_done));

   mpf_link_partner mpf_link_partner_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .rx_byte_valid(rx_byte_valid),
      .rx_byte(rx_byte), .rx_frame_end(rx_frame_end),
      .rx_frame_good(rx_frame_good), .tx_busy(tx_busy),
      .tx_pause_req(tx_pause_req), .tx_pause_value(tx_pause_value),
      .tx_pause_done(tx_pause_done));

   // ----------
   // Shared tasks
   // ----------
   task automatic final_report();
      $display("Checks: %0d, errors: %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic do_reset();
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask

   // Bounded wait: sel 0 watches the pause request, 1 the data allow
   task automatic wait_for(input int sel, input logic lvl, input int lim,
      output int n);
      n = 0;
      while (((sel == 0) ? tx_pause_req : tx_data_allow) !== lvl
         && n < lim) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask

   // ----------
   // Scenarios
   // ----------
   task automatic t_reset_vals();
      chk_reg(MPF_REG_CFG, 32'h04);
      chk_reg(MPF_REG_PTIME, 32'h4000);
      chk_reg(MPF_REG_THRESH, 32'h800);
      chk_reg(MPF_REG_TXCNT, 32'h0);
      chk_reg(MPF_REG_RXCNT, 32'h0);
      reg_write(MPF_REG_STATUS, 32'h3);
      chk_reg(MPF_REG_STATUS, 32'h0);
      chk_reg(8'h40, 32'h0);
      check(tx_data_allow, 1'b1);
   endtask

   task automatic t_own_pause();
      int n;
      reg_write(MPF_REG_CFG, 32'h24);
      rx_fifo_level <= 12'hfff; // Full FIFO must not block it
      mpf_link_partner_inst.send_frame(OWN_DA, MPF_TYPE_LO, 16'h0003);
      #1;
      check(rx_fc_discard, 1'b0);
      check(tx_data_allow, 1'b1);
      @(posedge clk_sys);
      #1;
      check(tx_data_allow, 1'b0);
      chk_reg(MPF_REG_STATUS, 32'h1);
      wait_for(1, 1'b1, 200, n);
      check(n >= 2 * SLOT - 8 && n <= 3 * SLOT, 1'b1);
      chk_reg(MPF_REG_RXCNT, 32'h1);
   endtask

   task automatic t_mcast();
      int n;
      mpf_link_partner_inst.send_frame(MPF_MCAST_DA, MPF_TYPE_LO, 16'h0100);
      #1;
      check(rx_fc_discard, 1'b1);
      wait_for(1, 1'b0, 4, n);
      check(tx_data_allow, 1'b0);
      mpf_link_partner_inst.send_frame(OWN_DA, 8'h81, 16'h0000);
      repeat (3) @(posedge clk_sys);
      #1;
      check(tx_data_allow, 1'b0);
      @(posedge clk_sys);
      rx_fifo_room <= 1'b0; // Own frame with no room is not stored
      mpf_link_partner_inst.send_frame(OWN_DA, MPF_TYPE_LO, 16'h0000);
      rx_fifo_room <= 1'b1;
      #1;
      check(rx_fc_discard, 1'b1);
      wait_for(1, 1'b1, 3, n);
      check(tx_data_allow, 1'b1);
      chk_reg(MPF_REG_RXCNT, 32'h3);
      reg_write(MPF_REG_CFG, 32'h00);
      mpf_link_partner_inst.send_frame(OWN_DA, MPF_TYPE_LO, 16'h0100);
      repeat (3) @(posedge clk_sys);
      #1;
      check(tx_data_allow, 1'b1);
   endtask

   task automatic t_send_resume();
      int n;
      mpf_link_partner_inst.done_delay = 10;
      @(posedge clk_sys);
      rx_fifo_level <= 12'h008;
      reg_write(MPF_REG_THRESH, 32'h10);
      reg_write(MPF_REG_PTIME, 32'h011f);
      reg_write(MPF_REG_CFG, 32'h15);
      repeat (5) @(posedge clk_sys);
      #1;
      check(tx_pause_req, 1'b0);
      @(posedge clk_sys);
      rx_fifo_level <= 12'h011;
      wait_for(0, 1'b1, 4, n);
      check(tx_pause_value, 32'h011f);
      chk_reg(MPF_REG_STATUS, 32'h2);
      wait_for(0, 1'b0, 20, n);
      @(posedge clk_sys);
      rx_fifo_level <= 12'h004;
      repeat (20) @(posedge clk_sys);
      #1;
      check(tx_pause_req, 1'b0);
      @(posedge clk_sys);
      rx_fifo_level <= 12'h000;
      wait_for(0, 1'b1, 4, n);
      check({tx_pause_req, tx_pause_value}, 32'h10000);
      wait_for(0, 1'b0, 20, n);
      check(mpf_link_partner_inst.last_value, 32'h0);
      chk_reg(MPF_REG_TXCNT, 32'h2);
   endtask

   task automatic t_short_repause();
      int n;
      do_reset();
      t_reset_vals();
      reg_write(MPF_REG_THRESH, 32'h10);
      reg_write(MPF_REG_PTIME, 32'h0017);
      reg_write(MPF_REG_CFG, 32'h0d);
      rx_fifo_level <= 12'h020;
      wait_for(0, 1'b1, 4, n);
      wait_for(0, 1'b0, 20, n);
      wait_for(0, 1'b1, 4, n);
      check({n < 4, tx_pause_value}, 32'h10017);
      @(posedge clk_sys);
      rx_fifo_level <= 12'h000;
      wait_for(0, 1'b0, 20, n);
      repeat (30) @(posedge clk_sys);
      #1;
      check(tx_pause_req, 1'b0);
      chk_reg(MPF_REG_TXCNT, 32'h2);
      // Resume mode alone with a short time: no zero-time frame follows
      reg_write(MPF_REG_CFG, 32'h15);
      rx_fifo_level <= 12'h020;
      wait_for(0, 1'b1, 4, n);
      @(posedge clk_sys);
      rx_fifo_level <= 12'h000;
      wait_for(0, 1'b0, 20, n);
      repeat (30) @(posedge clk_sys);
      #1;
      check(tx_pause_req, 1'b0);
      chk_reg(MPF_REG_TXCNT, 32'h3);
   endtask

   task automatic t_repause_resume();
      int n;
      reg_write(MPF_REG_PTIME, 32'h003f);
      reg_write(MPF_REG_CFG, 32'h1d);
      rx_fifo_level <= 12'h020;
      wait_for(0, 1'b1, 4, n);
      wait_for(0, 1'b0, 20, n);
      wait_for(0, 1'b1, 600, n);
      check(n > 31 * SLOT && n <= 32 * SLOT + 1, 1'b1);
      check(tx_pause_value, 32'h003f);
      wait_for(0, 1'b0, 20, n);
      @(posedge clk_sys);
      rx_fifo_level <= 12'h000;
      wait_for(0, 1'b1, 4, n);
      check({tx_pause_req, tx_pause_value}, 32'h10000);
      wait_for(0, 1'b0, 20, n);
      chk_reg(MPF_REG_TXCNT, 32'h6);
   endtask

   task automatic t_fast_slot();
      int n;
      int slot;
      slot = MPF_SLOT_CYC_100;
      reg_write(MPF_REG_CFG, 32'h04);
      link_speed_100 <= 1'b1;
      mpf_link_partner_inst.send_frame(OWN_DA, MPF_TYPE_LO, 16'h0002);
      wait_for(1, 1'b0, 4, n);
      wait_for(1, 1'b1, 1100, n);
      check(n > slot && n <= 2 * slot + 1, 1'b1);
   endtask

   // ----------
   // Main sequence and watchdog
   // ----------
   initial begin
      do_reset();
      t_reset_vals();
      t_own_pause();
      @(posedge clk_sys);
      rx_fifo_level <= 12'h000;
      t_mcast();
      t_send_resume();
      t_short_repause();
      t_repause_resume();
      t_fast_slot();
      final_report();
   end

   initial begin
      #400us;
      err_total++;
      final_report();
   end
endmodule // mpf_pause_ctrl_test

// File: mpf_pkg.sv
// Constants and types shared by the pause flow control block
package mpf_pkg;

   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] MPF_REG_CFG = 8'h00;
   localparam logic [7:0] MPF_REG_PTIME = 8'h04;
   localparam logic [7:0] MPF_REG_THRESH = 8'h08;
   localparam logic [7:0] MPF_REG_STATUS = 8'h0c;
   localparam logic [7:0] MPF_REG_TXCNT = 8'h10;
   localparam logic [7:0] MPF_REG_RXCNT = 8'h14;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int MPF_CFG_SEND_EN_BIT = 0;
   localparam int MPF_CFG_HONOR_BIT = 2;
   localparam int MPF_CFG_REPAUSE_BIT = 3;
   localparam int MPF_CFG_RESUME_BIT = 4;
   localparam int MPF_CFG_DROP_BIT = 5;
   localparam int MPF_STAT_PAUSED_BIT = 0;
   localparam int MPF_STAT_SENDING_BIT = 1;
   localparam logic [7:0] MPF_CFG_RST = 8'h04;
   localparam logic [15:0] MPF_PTIME_RST = 16'h4000;
   localparam logic [11:0] MPF_THRESH_RST = 12'h800;
   localparam logic [15:0] MPF_OWN_MASK = 16'hffe0;
   localparam logic [15:0] MPF_PTIME_MIN = 16'h0020;

   // ------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------
   localparam int MPF_FILL_W = 12;
   localparam logic [47:0] MPF_MCAST_DA = 48'h0180c2000001;
   localparam logic [5:0] MPF_POS_TYPE_HI = 6'h0c;
   localparam logic [5:0] MPF_POS_TYPE_LO = 6'h0d;
   localparam logic [5:0] MPF_POS_OP_HI = 6'h0e;
   localparam logic [5:0] MPF_POS_OP_LO = 6'h0f;
   localparam logic [5:0] MPF_POS_TIME_HI = 6'h10;
   localparam logic [5:0] MPF_POS_TIME_LO = 6'h11;
   localparam logic [5:0] MPF_POS_DA_END = 6'h06;
   localparam logic [5:0] MPF_FRAME_MIN = 6'h3c;
   localparam logic [7:0] MPF_TYPE_HI = 8'h88;
   localparam logic [7:0] MPF_TYPE_LO = 8'h80;
   localparam logic [7:0] MPF_OP_HI = 8'h00;
   localparam logic [7:0] MPF_OP_LO = 8'h01;

   // ------------------------------------------------------------
   // Slot timing
   // ------------------------------------------------------------
   localparam int MPF_SLOT_BITS = 512;
   localparam int MPF_CLK_NS = 10;
   localparam int MPF_BIT_NS_100 = 10;
   localparam int MPF_BIT_NS_10 = 100;
   localparam int MPF_SLOT_CYC_100 = MPF_SLOT_BITS * MPF_BIT_NS_100 / MPF_CLK_NS;
   localparam int MPF_SLOT_CYC_10 = MPF_SLOT_BITS * MPF_BIT_NS_10 / MPF_CLK_NS;

   typedef enum logic [3:0] {
      MPF_IDLE = 4'b0001,
      MPF_SEND = 4'b0010,
      MPF_WAIT = 4'b0100,
      MPF_XON = 4'b1000
   } mpf_state_t;

endpackage
